// ==== hdl/ccs_clock_switchover.sv ====
// cpu clock source and division switchover with oscillator control
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_switchover #(
	parameter int unsigned STAB_LEN = ccs_pkg::STAB_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        wr_en,
	input  wire logic [7:0]  wr_data,
	input  wire logic        sub_clk_pin,
	output var  logic [7:0]  processor_clock_ctrl,
	output var  logic        cpu_clk_en,
	output var  logic        instr_tick,
	output var  logic        cpu_hold,
	output var  logic        main_osc_run,
	output var  logic        active_clock_status
);
	import ccs_pkg::*;

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	ccs_div_t            cpu_div_sel, next_cpu_div_sel;
	logic                clock_source_select, next_clock_source_select;
	logic                main_osc_stop_ctrl, next_main_osc_stop_ctrl;
	ccs_div_t            act_div, next_act_div;
	logic                act_src, next_act_src;
	logic                pend, next_pend;
	logic [4:0]          pcnt, next_pcnt;
	logic                phase, next_phase;
	logic                sub_half, next_sub_half;
	logic                next_cpu_clk_en, next_instr_tick, next_main_osc_run;
	logic [2:0]          sub_sync;
	logic                sub_edge;
	logic [STAB_W-1:0]   stab_cnt;
	logic                stab_zero;
	logic [DLY_W-1:0]    sw_cnt;
	logic [DLY_W-1:0]    sw_load_val;
	logic                sw_load, sw_dec, sw_apply;
	ccs_div_t            ediv, wr_div;
	logic                wr_css, wr_change;
	logic [4:0]          pcnt_lim;

	// --------------------------------------------------------------
	// subsystem clock pin sync and edge
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			sub_sync <= 3'h0;
		end
		else
		begin
			sub_sync <= {sub_sync[1:0], sub_clk_pin};
		end
	end

	// only the second and third stages feed logic
	assign sub_edge = sub_sync[1] & ~sub_sync[2];

	// --------------------------------------------------------------
	// waits
	// --------------------------------------------------------------
	ccs_cycle_counter #(
		.WIDTH   (STAB_W),
		.RST_VAL (STAB_W'(STAB_LEN))
	) u_stab (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.load     (1'b0),
		.load_val ('0),
		.dec_en   (1'b1),
		.count    (stab_cnt),
		.zero     (stab_zero)
	);

	ccs_cycle_counter #(
		.WIDTH   (DLY_W),
		.RST_VAL ('0)
	) u_sw (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.load     (sw_load),
		.load_val (sw_load_val),
		.dec_en   (sw_dec),
		.count    (sw_cnt),
		.zero     ()
	);

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	// reserved codes run at the slowest rate rather than stopping the cpu
	assign ediv      = (act_div > DIV_SLOW) ? DIV_SLOW : act_div;
	assign pcnt_lim  = 5'((1 << ediv) - 1);
	assign wr_div    = wr_data[DIV_MSB:DIV_LSB];
	assign wr_css    = wr_data[SRC_SEL_BIT];
	assign wr_change = wr_en && (wr_div != act_div || wr_css != act_src);
	assign sw_load   = wr_change;
	assign sw_dec    = pend && instr_tick;
	assign sw_apply  = pend && instr_tick && sw_cnt == DLY_W'(1) && !wr_change;

	always_comb
	begin
		sw_load_val = DLY_W'(MAIN_DLY_MAX >> ediv);
		if (act_src)
		begin
			sw_load_val = SUB_LEAVE_DLY;
		end
		else if (wr_css)
		begin
			sw_load_val = ccs_sub_delay(ediv);
		end
	end

	always_comb
	begin
		next_cpu_div_sel         = cpu_div_sel;
		next_clock_source_select = clock_source_select;
		next_main_osc_stop_ctrl  = main_osc_stop_ctrl;
		next_act_div             = act_div;
		next_act_src             = act_src;
		next_pend                = pend;
		next_pcnt                = pcnt;
		next_phase               = phase;
		next_sub_half            = sub_half;
		next_cpu_clk_en          = 1'b0;
		next_instr_tick          = 1'b0;
		if (wr_en)
		begin
			// division and source may change together either way
			next_cpu_div_sel         = wr_div;
			next_clock_source_select = wr_css;
			next_main_osc_stop_ctrl  = wr_data[OSC_STOP_BIT];
		end
		if (wr_change)
		begin
			next_pend = 1'b1;
		end
		else if (sw_apply)
		begin
			next_pend    = 1'b0;
			next_act_div = cpu_div_sel;
			next_act_src = clock_source_select;
			next_pcnt    = 5'h0;
			next_phase   = 1'b0;
		end
		if (sub_edge)
		begin
			next_sub_half = ~sub_half;
		end
		if (!cpu_hold && !sw_apply)
		begin
			if (act_src)
			begin
				// fixed rate regardless of division field
				next_cpu_clk_en = sub_edge && sub_half;
			end
			else if (pcnt == pcnt_lim)
			begin
				next_cpu_clk_en = 1'b1;
				next_pcnt       = 5'h0;
			end
			else
			begin
				next_pcnt = pcnt + 5'h1;
			end
			if (next_cpu_clk_en)
			begin
				next_phase      = ~phase;
				next_instr_tick = phase;
			end
		end
		// stop only once the cpu has really left the main clock
		next_main_osc_run = !(next_main_osc_stop_ctrl && next_act_src);
	end

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			cpu_div_sel          <= CTRL_RST[DIV_MSB:DIV_LSB];
			clock_source_select  <= CTRL_RST[SRC_SEL_BIT];
			main_osc_stop_ctrl   <= CTRL_RST[OSC_STOP_BIT];
			act_div              <= DIV_SLOW;
			act_src              <= 1'b0;
			pend                 <= 1'b0;
			pcnt                 <= 5'h0;
			phase                <= 1'b0;
			sub_half             <= 1'b0;
			cpu_clk_en           <= 1'b0;
			instr_tick           <= 1'b0;
			cpu_hold             <= 1'b1;
			main_osc_run         <= 1'b0;
			active_clock_status  <= 1'b0;
			processor_clock_ctrl <= CTRL_RST;
		end
		else
		begin
			cpu_div_sel          <= next_cpu_div_sel;
			clock_source_select  <= next_clock_source_select;
			main_osc_stop_ctrl   <= next_main_osc_stop_ctrl;
			act_div              <= next_act_div;
			act_src              <= next_act_src;
			pend                 <= next_pend;
			pcnt                 <= next_pcnt;
			phase                <= next_phase;
			sub_half             <= next_sub_half;
			cpu_clk_en           <= next_cpu_clk_en;
			instr_tick           <= next_instr_tick;
			cpu_hold             <= !stab_zero;
			main_osc_run         <= next_main_osc_run;
			active_clock_status  <= next_act_src;
			processor_clock_ctrl <= {next_main_osc_stop_ctrl, 1'b0, next_act_src,
				next_clock_source_select, 1'b0, next_cpu_div_sel};
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	sequence s_setting_write;
		wr_change;
	endsequence

	sequence s_from_main_to_main;
		s_setting_write ##0 (!act_src && !wr_css);
	endsequence

	AST_RESET_VALUE: assert property ($past(srst) |->
		processor_clock_ctrl == CTRL_RST && !main_osc_run) else $error("reset value wrong");
	AST_HOLD_WAIT: assert property (!stab_zero |=> cpu_hold && !cpu_clk_en)
		else $error("cpu ran during stabilization");
	AST_SLOW_START: assert property (
		$fell(cpu_hold) |-> act_div == DIV_SLOW || pend)
		else $error("start not at slowest rate");
	AST_STATUS: assert property (
		active_clock_status == processor_clock_ctrl[ACT_STAT_BIT])
		else $error("status bit mismatch");
	AST_SWITCH_ON_TICK: assert property ($changed(act_src) || $changed(act_div) |->
		$past(instr_tick) && $past(pend)) else $error("switch off instruction edge");
	AST_MAIN_DELAY: assert property (s_from_main_to_main |=>
		sw_cnt == DLY_W'(MAIN_DLY_MAX >> ediv)) else $error("main delay wrong");
	AST_LEAVE_SUB: assert property (s_setting_write ##0 act_src |=>
		sw_cnt == SUB_LEAVE_DLY) else $error("leave subsystem delay wrong");
	AST_SUB_DELAY: assert property (s_setting_write ##0 (!act_src && wr_css) |=>
		sw_cnt == ccs_sub_delay($past(ediv))) else $error("subsystem delay wrong");
	AST_OSC_RESTART: assert property (wr_en && !wr_data[OSC_STOP_BIT] |=>
		##1 main_osc_run) else $error("main oscillator not restarted");
	// the stopped level left by reset is covered by the reset check above
	AST_OSC_STOP: assert property (!main_osc_run && !$past(srst) |->
		processor_clock_ctrl[OSC_STOP_BIT] && active_clock_status)
		else $error("main oscillator stopped early");
	// enable is registered one edge after the synchronised edge
	AST_SUB_RATE: assert property (cpu_clk_en && active_clock_status |->
		$past(sub_edge)) else $error("subsystem rate wrong");

endmodule
`default_nettype wire

// ==== hdl/ccs_pkg.sv ====
// constants and types for the cpu clock switchover block
// What this block does
// - cpu clock chosen by division field bits 2..0 and source select bit 4
// - new settings take effect only after some instructions on the old clock
// - bit 5 reports active source: 0 main clock, 1 subsystem clock
// - main-to-main delay 16,8,4,2,1 instructions by old code; leaving subsystem takes 1
// - main-to-subsystem delay is main freq over old division and subsystem freq
// - one write may change division and move source select from 1 to 0
// - after reset, main oscillator starts and cpu waits 2^17 main clocks
// - after that wait, execution starts at slowest main rate, 3.2 us
// - clearing bit 7 restarts main oscillation
// - reset loads 04H and holds the main oscillator stopped only while reset is asserted
// - with bit 7 set, main oscillation stops only once cpu runs on subsystem
// - on subsystem clock instruction time is fixed at 122 us
package ccs_pkg;

	localparam int unsigned MAIN_FREQ_HZ   = 10_000_000;
	localparam int unsigned SUB_FREQ_HZ    = 32_768;
	localparam int unsigned STAB_EXP       = 17;
	localparam int unsigned STAB_CYCLES    = 2 ** STAB_EXP;
	localparam int unsigned STAB_W         = 18;
	localparam int unsigned DLY_W          = 8;

	// --------------------------------------------------------------
	// control register layout
	// --------------------------------------------------------------
	localparam int unsigned DIV_LSB        = 0;
	localparam int unsigned DIV_MSB        = 2;
	localparam int unsigned SRC_SEL_BIT    = 4;
	localparam int unsigned ACT_STAT_BIT   = 5;
	localparam int unsigned OSC_STOP_BIT   = 7;
	localparam logic [7:0]  CTRL_RST       = 8'h04;
	localparam logic [2:0]  DIV_SLOW       = 3'h4;
	localparam logic [4:0]  MAIN_DLY_MAX   = 5'h10;
	localparam logic [DLY_W-1:0] SUB_LEAVE_DLY = 8'h01;

	typedef logic [2:0] ccs_div_t;

	// main to subsystem delay, rounded up to whole instructions
	function automatic logic [DLY_W-1:0] ccs_sub_delay(input ccs_div_t div);
		int unsigned d;
		d = (2 << div) * SUB_FREQ_HZ;
		return DLY_W'((MAIN_FREQ_HZ + d - 1) / d);
	endfunction

endpackage

// ==== hdl/ccs_cycle_counter.sv ====
// down counter with load, used for stabilization and switchover waits
`timescale 1ns/1ps
`default_nettype none
module ccs_cycle_counter #(
	parameter int unsigned         WIDTH   = 8,
	parameter logic [WIDTH-1:0]    RST_VAL = '0
) (
	input  wire logic              clk_sys,
	input  wire logic              srst,
	input  wire logic              load,
	input  wire logic [WIDTH-1:0]  load_val,
	input  wire logic              dec_en,
	output var  logic [WIDTH-1:0]  count,
	output var  logic              zero
);

	logic [WIDTH-1:0] next_count;

	always_comb
	begin
		next_count = count;
		if (load)
		begin
			next_count = load_val;
		end
		else if (dec_en && count != '0)
		begin
			next_count = count - WIDTH'(1);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			count <= RST_VAL;
		end
		else
		begin
			count <= next_count;
		end
	end

	assign zero = (count == '0);

endmodule
`default_nettype wire

// ==== testbench/ccs_sub_osc.sv ====
// subsystem oscillator model for the clock switchover bench
`timescale 1ns/1ps
`default_nettype none
module ccs_sub_osc #(
	parameter int unsigned HALF_NS = 300
) (
	input  wire logic run,
	output var  logic sub_clk_pin
);
	// --------------------------------------------------------------
	// free-running crystal
	// --------------------------------------------------------------
	// started early and never stopped, so it is stable before any switch
	// phase offset keeps its edges away from the main clock edges
	initial
	begin
		sub_clk_pin = 1'b0;
		wait (run);
		#37;
		forever #(HALF_NS) sub_clk_pin = ~sub_clk_pin;
	end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the cpu clock switchover block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ccs_pkg::*;
	localparam int unsigned STAB = 16;
	localparam logic [7:0]  TD [9] = '{8'h00, 8'h03, 8'h01, 8'h02, 8'h00, 8'h02, 8'h92, 8'h00, 8'h07};
	localparam int          TN [9] = '{1, 16, 2, 8, 4, 16, 39, 1, 16};
	localparam int          TP [9] = '{1, 8, 2, 4, 1, 4, 12, 1, 16};
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic        wr_en = 1'b0;
	logic [7:0]  wr_data = 8'h00;
	logic        osc_on = 1'b0;
	wire logic   sub_clk_pin;
	logic [7:0]  processor_clock_ctrl;
	logic        cpu_clk_en, instr_tick, cpu_hold, main_osc_run, active_clock_status;
	int          fail_count = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          last_pulse, iv, prev_iv, stable, ticks, mark_ticks, n;
	bit          marked;
	logic [23:0] notes [$];
	logic [31:0] seed = 32'h6671;

	always #50 clk_sys = ~clk_sys;

	ccs_clock_switchover #(.STAB_LEN(STAB)) u_ccs_clock_switchover (
		.clk_sys(clk_sys), .srst(srst), .wr_en(wr_en), .wr_data(wr_data),
		.sub_clk_pin(sub_clk_pin), .processor_clock_ctrl(processor_clock_ctrl),
		.cpu_clk_en(cpu_clk_en), .instr_tick(instr_tick), .cpu_hold(cpu_hold),
		.main_osc_run(main_osc_run), .active_clock_status(active_clock_status));
	ccs_sub_osc u_ccs_sub_osc (.run(osc_on), .sub_clk_pin(sub_clk_pin));

	// --------------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		if (fail_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// write just after a tick, so no tick lands on the write edge itself
	task automatic wr(input logic [7:0] d, input int tk, input int per);
		do @(posedge clk_sys); while (instr_tick !== 1'b1);
		seed = lfsr(seed);
		wr_en <= 1'b1;
		wr_data <= {d[7], seed[1:0], d[4:0]};
		if (tk > 0)
			notes.push_back({tk[7:0], per[7:0], d & 8'h97 | {2'h0, d[4], 5'h00}});
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask

	// --------------------------------------------------------------
	// watchdog and result monitor
	// --------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			finish_test();
		end
	end

	// a new cpu rate shows as two equal intervals that differ from the old one;
	// old-clock ticks are those seen before the first odd interval
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			stable = 0;
			prev_iv = 0;
			marked = 0;
			ticks = 0;
			last_pulse = cyc;
		end
		else
		begin
			if (cpu_clk_en)
			begin
				iv = cyc - last_pulse;
				last_pulse = cyc;
				if (iv != stable && !marked)
				begin
					marked = 1;
					mark_ticks = ticks;
				end
				if (iv == prev_iv && iv != stable)
				begin
					stable = iv;
					marked = 0;
					if (notes.size() == 0)
						check(32'h1, 32'h0);
					else
						check({8'h00, mark_ticks[7:0], iv[7:0], processor_clock_ctrl},
							{8'h00, notes.pop_front()});
				end
				prev_iv = iv;
			end
			if (wr_en)
				ticks = 0;
			else if (instr_tick)
				ticks++;
		end
	end

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge clk_sys);
		check(32'({processor_clock_ctrl, 7'h00, main_osc_run}), 32'h0400);
		notes.push_back(24'h001004);
		srst <= 1'b0;
		osc_on <= 1'b1;
		n = 0;
		while (n < 100)
		begin
			@(posedge clk_sys);
			#1;
			n++;
			if (cpu_hold !== 1'b1)
				break;
		end
		check(n, STAB + 1);
		while (notes.size() != 0) @(posedge clk_sys);
		for (int i = 0; i < 9; i++)
		begin
			wr(TD[i], TN[i], TP[i]);
			if (TD[i][7])
			begin
				repeat (3) @(posedge clk_sys);
				check(32'(main_osc_run), 32'h1);
			end
			while (notes.size() != 0) @(posedge clk_sys);
			if (TD[i][7])
			begin
				repeat (2) @(posedge clk_sys);
				check(32'({active_clock_status, main_osc_run}), 32'h2);
				wr(8'h12, 0, 0);
				repeat (3) @(posedge clk_sys);
				check(32'(main_osc_run), 32'h1);
				repeat (STAB * 2) @(posedge clk_sys);
			end
		end
		repeat (40) @(posedge clk_sys);
		finish_test();
	end
endmodule
`default_nettype wire
